// ---- logic/dbo_pkg.sv ----
// constants and carriers for the burst ordering and latency mode register block
// assumes one clock domain; commands arrive already decoded from the command bus
package dbo_pkg;

    // ----------------------------------------------------------------
    // mode register map
    // ----------------------------------------------------------------
    localparam logic [5:0] DBO_LAT_MR_ADDR     = 6'h02;
    localparam logic [7:0] DBO_LAT_MR_RESET    = 8'h00;
    localparam int         DBO_RL_LSB          = 0;
    localparam int         DBO_WL_LSB          = 3;
    localparam int         DBO_WLS_BIT         = 6;
    localparam int         DBO_WLEV_BIT        = 7;
    localparam logic [7:0] DBO_READBACK_MASK   = 8'hf8;

    // ----------------------------------------------------------------
    // burst geometry
    // ----------------------------------------------------------------
    localparam logic [4:0] DBO_LAST_BEAT_BL16  = 5'h0f;
    localparam logic [4:0] DBO_LAST_BEAT_BL32  = 5'h1f;

    // ----------------------------------------------------------------
    // command and beat carriers
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        DBO_CMD_READ  = 3'h0,
        DBO_CMD_WRITE = 3'h1,
        DBO_CMD_MRW   = 3'h2,
        DBO_CMD_MRR   = 3'h3,
        DBO_CMD_OTHER = 3'h4
    } dbo_kind_t;

    typedef struct packed {
        logic       valid;
        dbo_kind_t  kind;
        logic [5:0] mr_addr;
        logic [7:0] op;
        logic       bl32;    // burst_len_setting: 1 = 32 beats
        logic [2:0] col_hi;  // column_address_bits C4..C2
    } dbo_cmd_t;

    typedef struct packed {
        logic       valid;
        logic       is_write;
        logic       last;
        logic [4:0] col;     // beat address within the 32-beat block
    } dbo_beat_t;

    typedef struct packed {
        logic [5:0] read_latency;
        logic [4:0] read_to_precharge_cycles;
        logic [5:0] write_latency;
    } dbo_lat_t;

endpackage

// ---- logic/dbo_burst_seq.sv ----
// beat address sequencer for one read or write burst
// assumes start is only raised while ready is high
`timescale 1ns/1ps
`default_nettype none
module dbo_burst_seq
    import dbo_pkg::*;
(
    input  wire logic       clk,       // 250 MHz clock
    input  wire logic       arst_n,    // async reset, active low
    input  wire logic       start,     // take a burst this edge
    input  wire logic       is_write,  // burst direction
    input  wire logic       bl32,      // 32 beats when high
    input  wire logic [2:0] col_hi,    // C4..C2 of the command
    output logic            ready,     // may start a burst
    output dbo_beat_t       beat       // registered beat stream
);

    // ----------------------------------------------------------------
    // beat address arithmetic
    // ----------------------------------------------------------------
    function automatic logic [4:0] beat_col(input logic [4:0] k, input logic wr,
                                            input logic l32, input logic half,
                                            input logic [1:0] off);
        logic [3:0] lo;
        logic       hi;
        lo = wr ? k[3:0] : 4'({off, 2'b00} + k[3:0]);
        hi = 1'b0;
        if (l32) begin
            hi = wr ? k[4] : (half ^ k[4]);
        end
        return {hi, lo};
    endfunction

    logic       busy_r;
    logic [4:0] cnt_r;
    logic       wr_r;
    logic       l32_r;
    logic       half_r;
    logic [1:0] off_r;

    // C1:C0 never arrive, so the start sits on a 4-beat boundary
    wire logic [1:0] new_off  = is_write ? 2'b00 : col_hi[1:0];
    wire logic       new_half = is_write ? 1'b0 : col_hi[2];
    wire logic [4:0] last_k   = l32_r ? DBO_LAST_BEAT_BL32 : DBO_LAST_BEAT_BL16;
    wire logic       at_last  = (cnt_r == last_k);

    assign ready = ~busy_r;

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            cnt_r  <= 5'h00;
            wr_r   <= 1'b0;
            l32_r  <= 1'b0;
            half_r <= 1'b0;
            off_r  <= 2'b00;
            beat   <= '0;
        end else if (start && !busy_r) begin
            busy_r <= 1'b1;
            cnt_r  <= 5'h01;
            wr_r   <= is_write;
            l32_r  <= bl32;
            half_r <= new_half;
            off_r  <= new_off;
            beat   <= '{1'b1, is_write, 1'b0, beat_col(5'h00, is_write, bl32, new_half, new_off)};
        end else if (busy_r) begin
            busy_r <= ~at_last;
            cnt_r  <= 5'(cnt_r + 5'h01);
            beat   <= '{1'b1, wr_r, at_last, beat_col(cnt_r, wr_r, l32_r, half_r, off_r)};
        end else begin
            beat   <= '0;
        end
    end

endmodule
`default_nettype wire

// ---- logic/dbo_top.sv ----
// latency mode register with two set-point copies, write leveling hold
// and burst address ordering for reads and writes
// assumes commands are decoded on clk; set-point and inversion bits come from
// sibling mode registers on the same clock
//
// Functional notes
// - 16-beat read starts at C3:C2 times four, wraps modulo 16, ignores C4.
// - reads start on 4-beat boundary; low two column bits absent, taken as zero.
// - device treats the two lowest column bits as zero on every burst.
// - writes run plain ascending from burst start for 16 and 32 beats.
// - latency register at address 2: RL 2:0, WL 5:3, set select 6, leveling 7.
// - read latency 6..36 and read-to-precharge 8..16 without read inversion.
// - read latency 6,12,16,22,28 with read inversion; upper codes uncertain.
// - write latency set A codes give 4 to 18 in steps of two.
// - write latency set B codes give 4,8,12,18,22,26,30,34.
// - set select 0 picks A by default; leveling off until written one.
// - after leveling bit set, stay in write state until a write clears it.
// - two copies per bit; a write updates only the write-selected copy.
// - operation uses only the operating-selected copy; inactive copy is free; leveling here follows bit 7 of any write, to either copy.
`timescale 1ns/1ps
`default_nettype none
module dbo_top
    import dbo_pkg::*;
(
    input  wire logic       clk,                        // 250 MHz clock
    input  wire logic       arst_n,                     // async reset, active low
    input  wire dbo_cmd_t   cmd,                        // decoded command
    input  wire logic       set_point_write_select,     // copy written by mrw
    input  wire logic       set_point_operating_select, // copy in use
    input  wire logic       read_inversion_enable,      // read inversion on
    output dbo_beat_t       beat,                       // burst beat stream
    output dbo_lat_t        lat,                        // active latencies
    output logic            write_leveling_active,      // leveling hold state
    output logic            mrr_valid,                  // readback strobe
    output logic [7:0]      mrr_data,                   // readback value
    output logic            cmd_refused                 // command ignored
);

    // ----------------------------------------------------------------
    // latency tables
    // ----------------------------------------------------------------
    function automatic dbo_lat_t lat_decode(input logic [7:0] mr, input logic inv);
        dbo_lat_t r;
        r = '0;
        if (!inv) begin
            case (mr[DBO_RL_LSB +: 3])
                3'h0: begin
                    r.read_latency             = 6'd6;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h1: begin
                    r.read_latency             = 6'd10;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h2: begin
                    r.read_latency             = 6'd14;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h3: begin
                    r.read_latency             = 6'd20;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h4: begin
                    r.read_latency             = 6'd24;
                    r.read_to_precharge_cycles = 5'd10;
                end
                3'h5: begin
                    r.read_latency             = 6'd28;
                    r.read_to_precharge_cycles = 5'd12;
                end
                3'h6: begin
                    r.read_latency             = 6'd32;
                    r.read_to_precharge_cycles = 5'd14;
                end
                default: begin
                    r.read_latency             = 6'd36;
                    r.read_to_precharge_cycles = 5'd16;
                end
            endcase
        end else begin
            case (mr[DBO_RL_LSB +: 3])
                3'h0: begin
                    r.read_latency             = 6'd6;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h1: begin
                    r.read_latency             = 6'd12;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h2: begin
                    r.read_latency             = 6'd16;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h3: begin
                    r.read_latency             = 6'd22;
                    r.read_to_precharge_cycles = 5'd8;
                end
                3'h4: begin
                    r.read_latency             = 6'd28;
                    r.read_to_precharge_cycles = 5'd10;
                end
                3'h5: begin
                    r.read_latency             = 6'd28;
                    r.read_to_precharge_cycles = 5'd12;
                end
                3'h6: begin
                    r.read_latency             = 6'd36;
                    r.read_to_precharge_cycles = 5'd14;
                end
                default: begin
                    r.read_latency             = 6'd36;
                    r.read_to_precharge_cycles = 5'd16;
                end
            endcase
        end
        if (!mr[DBO_WLS_BIT]) begin
            case (mr[DBO_WL_LSB +: 3])
                3'h0: r.write_latency = 6'd4;
                3'h1: r.write_latency = 6'd6;
                3'h2: r.write_latency = 6'd8;
                3'h3: r.write_latency = 6'd10;
                3'h4: r.write_latency = 6'd12;
                3'h5: r.write_latency = 6'd14;
                3'h6: r.write_latency = 6'd16;
                default: r.write_latency = 6'd18;
            endcase
        end else begin
            case (mr[DBO_WL_LSB +: 3])
                3'h0: r.write_latency = 6'd4;
                3'h1: r.write_latency = 6'd8;
                3'h2: r.write_latency = 6'd12;
                3'h3: r.write_latency = 6'd18;
                3'h4: r.write_latency = 6'd22;
                3'h5: r.write_latency = 6'd26;
                3'h6: r.write_latency = 6'd30;
                default: r.write_latency = 6'd34;
            endcase
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // leveling state machine
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DBO_ST_RUN   = 2'b01,
        DBO_ST_LEVEL = 2'b10
    } dbo_state_t;

    dbo_state_t state_r;
    dbo_state_t state_nxt;
    logic [7:0] copy_r [2];
    logic       seq_ready;

    wire logic is_lat_mr  = (cmd.mr_addr == DBO_LAT_MR_ADDR);
    wire logic is_mrw_lat = cmd.valid && (cmd.kind == DBO_CMD_MRW) && is_lat_mr;
    // while leveling, only a write of this register that clears the bit is taken
    wire logic lvl_exit   = is_mrw_lat && !cmd.op[DBO_WLEV_BIT];
    wire logic in_level   = (state_r == DBO_ST_LEVEL);
    wire logic is_burst   = (cmd.kind == DBO_CMD_READ) || (cmd.kind == DBO_CMD_WRITE);
    wire logic lvl_block  = in_level && cmd.valid && !lvl_exit;
    // a burst arriving while one is still running is dropped, not queued
    wire logic busy_block = cmd.valid && !in_level && is_burst && !seq_ready;
    wire logic take       = cmd.valid && !lvl_block && !busy_block;
    wire logic do_mrw     = take && is_mrw_lat;
    wire logic do_mrr     = take && (cmd.kind == DBO_CMD_MRR);
    wire logic do_burst   = take && is_burst;
    wire logic [7:0] rd_copy  = copy_r[set_point_write_select];
    wire logic [7:0] op_copy  = copy_r[set_point_operating_select];
    wire dbo_lat_t   lat_nxt  = lat_decode(op_copy, read_inversion_enable);

    always_comb begin
        case (state_r)
            DBO_ST_RUN:   state_nxt = (do_mrw && cmd.op[DBO_WLEV_BIT]) ? DBO_ST_LEVEL
                                                                       : DBO_ST_RUN;
            DBO_ST_LEVEL: state_nxt = do_mrw ? DBO_ST_RUN : DBO_ST_LEVEL;
            default:      state_nxt = DBO_ST_RUN;
        endcase
    end

    // ----------------------------------------------------------------
    // register copies and registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r               <= DBO_ST_RUN;
            copy_r[0]             <= DBO_LAT_MR_RESET;
            copy_r[1]             <= DBO_LAT_MR_RESET;
            lat                   <= '0;
            write_leveling_active <= 1'b0;
            mrr_valid             <= 1'b0;
            mrr_data              <= 8'h00;
            cmd_refused           <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (do_mrw) begin
                copy_r[set_point_write_select] <= cmd.op;
            end
            lat                   <= lat_nxt;
            write_leveling_active <= (state_nxt == DBO_ST_LEVEL);
            mrr_valid             <= do_mrr;
            mrr_data              <= (do_mrr && is_lat_mr) ? (rd_copy & DBO_READBACK_MASK)
                                                           : 8'h00;
            cmd_refused           <= lvl_block || busy_block;
        end
    end

    // ----------------------------------------------------------------
    // burst ordering
    // ----------------------------------------------------------------
    dbo_burst_seq u_seq (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (do_burst),
        .is_write (cmd.kind == DBO_CMD_WRITE),
        .bl32     (cmd.bl32),
        .col_hi   (cmd.col_hi),
        .ready    (seq_ready),
        .beat     (beat)
    );

endmodule
`default_nettype wire

// ---- verif/dbo_top_assertions.sv ----
// checker for burst ordering and leveling hold at the dbo_top ports
// assumes it is bound into every dbo_top instance
`timescale 1ns/1ps
`default_nettype none
module dbo_top_checker
    import dbo_pkg::*;
(
    input wire logic       clk,                   // clock
    input wire logic       arst_n,                // async reset, active low
    input wire dbo_cmd_t   cmd,                   // command
    input wire dbo_beat_t  beat,                  // beat stream
    input wire logic       write_leveling_active, // leveling hold
    input wire logic       mrr_valid,             // readback strobe
    input wire logic [7:0] mrr_data,              // readback value
    input wire logic       cmd_refused            // refusal pulse
);
    wire mrw2 = cmd.valid && cmd.kind == DBO_CMD_MRW && cmd.mr_addr == DBO_LAT_MR_ADDR;
    wire clr  = mrw2 && !cmd.op[7];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_write_ascend: assert property (
        beat.valid && beat.is_write && !beat.last |=> beat.valid && beat.col == $past(beat.col) + 5'h01)
        else $error("write beat not ascending");
    a_read_rotate: assert property (
        beat.valid && !beat.is_write && !beat.last |=> beat.col[3:0] == $past(beat.col[3:0]) + 4'h1)
        else $error("read beat not wrapping by one");
    a_read_start: assert property (
        beat.valid && !beat.is_write && (!$past(beat.valid) || $past(beat.last)) |-> beat.col[1:0] == 2'h0)
        else $error("read start off boundary");
    a_write_start: assert property (
        beat.valid && beat.is_write && (!$past(beat.valid) || $past(beat.last)) |-> beat.col == 5'h00)
        else $error("write start not zero");
    a_level_enter: assert property (
        mrw2 && cmd.op[7] && !write_leveling_active |=> write_leveling_active)
        else $error("leveling not entered");
    a_level_hold: assert property (
        write_leveling_active && !clr |=> write_leveling_active) else $error("leveling dropped");
    a_level_exit: assert property (
        write_leveling_active && clr |=> !write_leveling_active) else $error("leveling not left");
    a_level_refuse: assert property (
        write_leveling_active && cmd.valid && !clr |=> cmd_refused && !mrr_valid)
        else $error("command taken while leveling");
    a_mrr_answer: assert property (
        cmd.valid && cmd.kind == DBO_CMD_MRR && !write_leveling_active |=> mrr_valid && !cmd_refused)
        else $error("readback missing");
    a_mrr_mask: assert property (
        mrr_valid |-> mrr_data[2:0] == 3'h0) else $error("read latency field visible");
endmodule
bind dbo_top dbo_top_checker chk (.clk(clk), .arst_n(arst_n), .cmd(cmd), .beat(beat),
    .write_leveling_active(write_leveling_active), .mrr_valid(mrr_valid),
    .mrr_data(mrr_data), .cmd_refused(cmd_refused));
`default_nettype wire

// ---- verif/dbo_host_model.sv ----
// controller model: puts one decoded command on the command bus per send
// assumes send is called just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module dbo_host_model
    import dbo_pkg::*;
(
    input  wire logic     clk, // clock
    output var  dbo_cmd_t cmd  // command to the device
);
    initial cmd = '0;
    task automatic send(input dbo_kind_t k, input logic [5:0] a, input logic [7:0] op,
                        input logic l32, input logic [2:0] c);
        dbo_cmd_t n;
        n = '{1'b1, k, a, op, l32, c};
        // writes carry no start offset, so they sit on their own boundary
        if (k == DBO_CMD_WRITE) n.col_hi = 3'h0;
        cmd <= n;
        @(posedge clk);
        cmd.valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/dbo_top_test.sv ----
// self-checking bench: burst orders, latency tables, set points, leveling
// assumes dbo_host_model drives cmd and the bound checker watches the ports
`timescale 1ns/1ps
`default_nettype none
module dbo_top_test import dbo_pkg::*; ;
    localparam int RL_N[8] = '{6, 10, 14, 20, 24, 28, 32, 36};
    localparam int RL_I[8] = '{6, 12, 16, 22, 28, 28, 36, 36};
    localparam int RTP[8]  = '{8, 8, 8, 8, 10, 12, 14, 16};
    localparam int WL_A[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
    localparam int WL_B[8] = '{4, 8, 12, 18, 22, 26, 30, 34};
    logic       clk, arst_n, wsel, osel, inv, wlev, mrr_valid, cmd_refused;
    logic [7:0] mrr_data;
    dbo_cmd_t   cmd;
    dbo_beat_t  beat;
    dbo_lat_t   lat;
    logic [6:0] qb[$];
    logic [7:0] qm[$];
    int         qr, bad_count, n_compared;
    dbo_top dut (.clk(clk), .arst_n(arst_n), .cmd(cmd), .set_point_write_select(wsel),
        .set_point_operating_select(osel), .read_inversion_enable(inv), .beat(beat),
        .lat(lat), .write_leveling_active(wlev), .mrr_valid(mrr_valid),
        .mrr_data(mrr_data), .cmd_refused(cmd_refused));
    dbo_host_model host (.clk(clk), .cmd(cmd));
    function automatic dbo_lat_t exp_lat(input logic [7:0] op, input logic iv);
        return '{6'(iv ? RL_I[op[2:0]] : RL_N[op[2:0]]), 5'(RTP[op[2:0]]),
                 6'(op[6] ? WL_B[op[5:3]] : WL_A[op[5:3]])};
    endfunction
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // next burst goes out in the cycle that shows the last beat
    task automatic burst(input logic w, input logic l32, input logic [2:0] c);
        int n;
        n = l32 ? 32 : 16;
        for (int k = 0; k < n; k++)
            qb.push_back(w ? {k == n - 1, 1'b1, 5'(k)} :
                {k == n - 1, 1'b0, l32 & (c[2] ^ (k > 15)), 4'(c[1:0] * 4 + k)});
        host.send(w ? DBO_CMD_WRITE : DBO_CMD_READ, 6'h00, 8'h00, l32, c);
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic mrw(input logic [7:0] op, input dbo_lat_t e);
        host.send(DBO_CMD_MRW, DBO_LAT_MR_ADDR, op, 1'b0, 3'h0);
        @(posedge clk);
        #1;
        check(lat === e, "latency");
        @(posedge clk);
    endtask
    always @(negedge clk) begin
        if (beat.valid === 1'b1)
            check(qb.size() > 0 && {beat.last, beat.is_write, beat.col} === qb.pop_front(),
                  "beat order");
        if (mrr_valid === 1'b1)
            check(qm.size() > 0 && mrr_data === qm.pop_front(), "readback");
        if (cmd_refused === 1'b1) begin
            check(qr > 0, "refusal");
            qr--;
        end
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
    initial begin
        logic [7:0] op;
        logic       iv;
        {arst_n, wsel, osel, inv, qr, bad_count, n_compared} = '0;
        void'($urandom(32'hc36bc5fc));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(lat === exp_lat(8'h00, 1'b0), "reset latency");
        @(posedge clk);
        for (int i = 0; i < 12; i++)
            burst(1'b0, i > 3, i > 3 ? 3'(i - 4) : {1'($urandom), 2'(i)});
        for (int k = 0; k < 16; k++)
            qb.push_back({k == 15, 1'b0, 1'b0, 4'(8 + k)});
        host.send(DBO_CMD_READ, 6'h00, 8'h00, 1'b0, 3'h2);
        @(posedge clk);
        qr++;
        host.send(DBO_CMD_WRITE, 6'h00, 8'h00, 1'b0, 3'h0);
        repeat (13) @(posedge clk);
        burst(1'b1, 1'b0, 3'h7);
        burst(1'b1, 1'b1, 3'h5);
        repeat (34) @(posedge clk);
        $display("test bursts done");
        for (int i = 0; i < 16; i++) begin
            op = {1'b0, 1'(i >> 3), 3'(i), 3'(i)};
            iv = 1'(i >> 3) ^ 1'(i);
            inv <= iv;
            mrw(op, exp_lat(op, iv));
        end
        $display("test latency done");
        inv <= 1'b0;
        wsel <= 1'b1;
        mrw(8'h1a, exp_lat(8'h7f, 1'b0));
        osel <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(lat === exp_lat(8'h1a, 1'b0), "operating copy");
        @(posedge clk);
        qm.push_back(8'h18);
        host.send(DBO_CMD_MRR, DBO_LAT_MR_ADDR, 8'h00, 1'b0, 3'h0);
        wsel <= 1'b0;
        @(posedge clk);
        qm.push_back(8'h78);
        host.send(DBO_CMD_MRR, DBO_LAT_MR_ADDR, 8'h00, 1'b0, 3'h0);
        @(posedge clk);
        mrw(8'h80, exp_lat(8'h1a, 1'b0));
        check(wlev === 1'b1, "leveling entry");
        qr += 2;
        host.send(DBO_CMD_READ, 6'h00, 8'h00, 1'b0, 3'h1);
        @(posedge clk);
        host.send(DBO_CMD_MRW, 6'h03, 8'h00, 1'b0, 3'h0);
        @(posedge clk);
        mrw(8'h00, exp_lat(8'h1a, 1'b0));
        check(wlev === 1'b0, "leveling exit");
        repeat (4) @(posedge clk);
        check(qb.size() == 0 && qm.size() == 0 && qr == 0, "results seen");
        $display("test set points and leveling done");
        end_of_test();
    end
endmodule
`default_nettype wire
